// file: verilog/nv_write_pkg.sv
// Behaviour
// - After write command and address, host shifts one data word of 8 or 16 bits.
// - Chip select falling after last data bit starts timed erase-then-program cycle.
// - Chip select low at least 250 ns then high shows ready/busy on serial output (here only if raised while programming runs).
// - Serial output low while programming runs, high once done and ready.
// - Write-entire-array programs every location with the single supplied word.
// - Write-entire-array cycle starts on chip select fall, needs no serial clocks.
// - Write-entire-array erases the whole array before programming it.
// - Write-entire-array takes effect only in the programming-enabled state.
// - During write-entire-array, chip select raised after 250 ns low shows status.
// - Start bit is first rising serial clock with chip select and serial input high.
// - Opcode, address and data are sampled on rising serial clock edges.
// - Command executes only if all its bits arrived before chip select falls.
// - Reset leaves programming disabled; writes ignored until enable command.
package nv_write_pkg;
    // ==========================================================
    // Opcodes
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    // Extended opcodes (two top address bits)
    localparam logic [1:0] EXT_DIS  = 2'h0;
    localparam logic [1:0] EXT_WRITE_ENTIRE_ARRAY = 2'h1;
    localparam logic [1:0] EXT_ERASE_ENTIRE_ARRAY = 2'h2;
    localparam logic [1:0] EXT_EN   = 2'h3;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS   = 25;
    localparam int CS_LOW_MIN_NS   = 250;
    localparam int CS_LOW_MIN_CYC  = (CS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_TIME_US    = 6000;
    localparam int PROG_CYC_DEF    = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
    // ==========================================================
    // Reset values
    localparam logic PROG_EN_RESET = 1'b0;
endpackage

// file: verilog/pin_sync.sv
// ==========================================================
// Three-stage synchroniser; a change counts when stages 2 and 3 agree
module pin_sync (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic reset_n,
    // Pin
    input  wire logic pinIn,
    output logic      pinOut
);
    logic s1_q, s2_q, s3_q;

    // Shift chain
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered level
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinOut <= 1'b0;
        end else if (s2_q == s3_q) begin
            pinOut <= s3_q;
        end
    end
endmodule

// file: verilog/serial_eeprom_write_cycle.sv
module serial_eeprom_write_cycle #(
    parameter int WORD_BITS = 8,
    parameter int ADDR_BITS = 9,
    parameter int PROG_CYC  = nv_write_pkg::PROG_CYC_DEF
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    // Serial pins
    input  wire logic                 chipSel,
    input  wire logic                 serialClk,
    input  wire logic                 serialIn,
    output logic                      serialOut,
    output logic                      serialOutEn,
    // Memory array port
    output logic                      memWe,
    output logic                      memAll,
    output logic [ADDR_BITS-1:0]      memAddr,
    output logic [WORD_BITS-1:0]      memData,
    output logic                      memErase,
    // Status
    output logic                      progEnabled,
    output logic                      busy
);
    localparam int FRAME_BITS = 2 + ADDR_BITS + WORD_BITS;
    localparam int CW = $clog2(FRAME_BITS + 2);
    localparam int TW = $clog2(PROG_CYC + 1);

    initial begin
        if (WORD_BITS != 8 && WORD_BITS != 16) $error("WORD_BITS must be 8 or 16");
        if (ADDR_BITS < 3 || PROG_CYC < 4) $error("Unsupported parameters");
    end

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_DONE  = 4'b0100,
        ST_PROG  = 4'b1000
    } state_t;

    // ==========================================================
    // Input synchronisation
    logic csS, sckS, sdiS;
    pin_sync uCs  (.core_clk(core_clk), .reset_n(reset_n), .pinIn(chipSel),   .pinOut(csS));
    pin_sync uSck (.core_clk(core_clk), .reset_n(reset_n), .pinIn(serialClk), .pinOut(sckS));
    pin_sync uSdi (.core_clk(core_clk), .reset_n(reset_n), .pinIn(serialIn),  .pinOut(sdiS));

    logic sckPrev_q, csPrev_q;
    logic sckRise, csFall, csRise;
    assign sckRise = sckS & ~sckPrev_q;
    assign csFall  = ~csS & csPrev_q;
    assign csRise  = csS & ~csPrev_q;

    // Edge history
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sckPrev_q <= 1'b0;
            csPrev_q  <= 1'b0;
        end else begin
            sckPrev_q <= sckS;
            csPrev_q  <= csS;
        end
    end

    // ==========================================================
    // Command shifter
    state_t              state_q;
    logic [FRAME_BITS-1:0] shift_q;
    logic [CW-1:0]       count_q;
    logic [TW-1:0]       timer_q;
    logic                phase_q;     // 0 erase, 1 program
    logic                isAll_q;
    logic                progEn_q;
    logic [1:0]          opcode_q;    // Latched as it passes the shifter
    logic [1:0]          extCode_q;   // Top two address bits, latched likewise

    logic [1:0] opcode;
    logic [1:0] extCode;
    logic       needData;
    logic [CW-1:0] needBits;
    // Short frames never reach the top of the shifter, so decode from latched copies
    assign opcode   = opcode_q;
    assign extCode  = extCode_q;
    assign needData = (opcode == nv_write_pkg::OP_WRITE) ||
                      (opcode == nv_write_pkg::OP_EXT && extCode == nv_write_pkg::EXT_WRITE_ENTIRE_ARRAY);
    assign needBits = needData ? CW'(FRAME_BITS) : CW'(2 + ADDR_BITS);

    // Whether the received frame starts a programming cycle
    logic startWrite;
    assign startWrite = progEn_q && needData;

    // Main sequencer
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            shift_q <= '0;
            count_q <= '0;
            timer_q <= '0;
            phase_q <= 1'b0;
            isAll_q <= 1'b0;
            opcode_q  <= 2'h0;
            extCode_q <= 2'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (sckRise && csS && sdiS) begin
                        state_q <= ST_SHIFT;
                        count_q <= '0;
                    end
                end
                ST_SHIFT: begin
                    if (!csS) begin
                        state_q <= ST_IDLE;
                    end else if (sckRise) begin
                        shift_q <= {shift_q[FRAME_BITS-2:0], sdiS};
                        count_q <= count_q + 1'b1;
                        if (count_q == CW'(1))
                            opcode_q <= {shift_q[0], sdiS};
                        if (count_q == CW'(3))
                            extCode_q <= {shift_q[0], sdiS};
                        if (count_q + 1'b1 >= needBits && count_q >= CW'(2 + ADDR_BITS - 1))
                            state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (!csS) begin
                        if (startWrite) begin
                            state_q <= ST_PROG;
                            timer_q <= TW'(PROG_CYC / 2);
                            phase_q <= 1'b0;
                            isAll_q <= (opcode == nv_write_pkg::OP_EXT);
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_PROG: begin
                    // no decoding until the timed cycle ends
                    if (timer_q != '0) begin
                        timer_q <= timer_q - 1'b1;
                    end else if (!phase_q) begin
                        phase_q <= 1'b1;
                        timer_q <= TW'(PROG_CYC - PROG_CYC / 2);
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Enable and disable commands
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            progEn_q <= nv_write_pkg::PROG_EN_RESET;
        end else if (state_q == ST_DONE && !csS && opcode == nv_write_pkg::OP_EXT) begin
            if (extCode == nv_write_pkg::EXT_EN) progEn_q <= 1'b1;
            else if (extCode == nv_write_pkg::EXT_DIS) progEn_q <= 1'b0;
        end
    end

    // ==========================================================
    // Array update strobes: erase at phase end, then program
    logic phaseEnd;
    assign phaseEnd = (state_q == ST_PROG) && (timer_q == '0);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            memWe    <= 1'b0;
            memErase <= 1'b0;
            memAll   <= 1'b0;
            memAddr  <= '0;
            memData  <= '0;
        end else begin
            memWe    <= phaseEnd;
            memErase <= phaseEnd && !phase_q;
            memAll   <= isAll_q;
            memAddr  <= shift_q[WORD_BITS +: ADDR_BITS];
            memData  <= shift_q[WORD_BITS-1:0];
        end
    end

    // ==========================================================
    // Ready/busy status: chip select low long enough, then high
    logic [CW-1:0] lowCnt_q;
    logic          lowOk_q;
    logic          statusOn_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowCnt_q   <= '0;
            lowOk_q    <= 1'b0;
            statusOn_q <= 1'b0;
        end else begin
            if (csS) lowCnt_q <= '0;
            else if (lowCnt_q < CW'(nv_write_pkg::CS_LOW_MIN_CYC)) lowCnt_q <= lowCnt_q + 1'b1;
            if (csFall) lowOk_q <= 1'b0;
            else if (!csS && lowCnt_q >= CW'(nv_write_pkg::CS_LOW_MIN_CYC - 1))
                lowOk_q <= 1'b1;
            if (!csS) statusOn_q <= 1'b0;
            else if (csRise && lowOk_q && state_q == ST_PROG) statusOn_q <= 1'b1;
        end
    end

    // Drive serial output
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            serialOut   <= 1'b0;
            serialOutEn <= 1'b0;
        end else begin
            serialOutEn <= statusOn_q && csS;
            serialOut   <= (state_q != ST_PROG);
        end
    end

    assign progEnabled = progEn_q;
    assign busy        = (state_q == ST_PROG);

    // ==========================================================
    // Checks
    sequence seqFrameDone;
        state_q == ST_DONE && !csS && startWrite;
    endsequence

    chk_prog_start: assert property (@(posedge core_clk) disable iff (!reset_n)
        seqFrameDone |=> state_q == ST_PROG) else $error("cycle did not start");
    chk_disabled_ignore: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_q == ST_DONE && !csS && !progEn_q |=> state_q == ST_IDLE)
        else $error("write while disabled");
    chk_busy_low: assert property (@(posedge core_clk) disable iff (!reset_n)
        serialOutEn && $past(state_q == ST_PROG) |-> !serialOut) else $error("busy not low");
    chk_short_abort: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_q == ST_SHIFT && !csS |=> state_q == ST_IDLE) else $error("short frame ran");
    chk_no_clock_need: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_q == ST_PROG && timer_q != '0 |=> state_q == ST_PROG) else $error("cycle stopped");
    chk_erase_first: assert property (@(posedge core_clk) disable iff (!reset_n)
        memWe && !memErase |-> $past(phase_q)) else $error("program before erase");
    chk_start_bit: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_q == ST_IDLE && sckRise && csS && sdiS |=> state_q == ST_SHIFT)
        else $error("start missed");
    chk_no_decode: assert property (@(posedge core_clk) disable iff (!reset_n)
        state_q == ST_PROG |=> state_q inside {ST_PROG, ST_IDLE}) else $error("decode busy");
    chk_status_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(statusOn_q) |-> $past(lowOk_q)) else $error("status too early");
endmodule

// file: testbench/three_wire_host.sv
// ==========================================================
// Host side of the three-wire serial link
module three_wire_host (
    // Clock
    input  wire logic core_clk,
    // Serial pins
    output logic      chipSel,
    output logic      serialClk,
    output logic      serialIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels: not selected, serial clock parked low
    initial begin
        chipSel   = 1'b0;
        serialClk = 1'b0;
        serialIn  = 1'b1;
    end

    // Wait a number of core clock edges
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Shift a frame MSB first at 200 ns per bit, then drop select to launch it
    task automatic send_frame(input logic [31:0] bits, input int n);
        chipSel <= 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            serialIn <= bits[i];
            tick(4);
            serialClk <= 1'b1;
            tick(4);
            serialClk <= 1'b0;
        end
        tick(4);
        serialIn <= ~bits[0];                       // Released line shows no stale bit
        chipSel  <= 1'b0;
    endtask

    // Hold select low past the minimum, then raise it to ask for status
    task automatic raise_for_status();
        tick(12);
        chipSel <= 1'b1;
        tick(6);
    endtask

    // End a status poll; select stays low past the minimum before the next frame
    task automatic drop_select();
        chipSel <= 1'b0;
        tick(12);
    endtask
endmodule

// file: testbench/serial_eeprom_write_cycle_tb_top.sv
module serial_eeprom_write_cycle_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] bits; int n; logic expBusy; logic expAll;} row_t;
    logic       core_clk, reset_n, chipSel, serialClk, serialIn, serialOut, serialOutEn;
    logic       memWe, memAll, memErase, progEnabled, busy, allSeen;
    logic [8:0] memAddr, addrSeen;
    logic [7:0] memData, dataSeen;
    int         fails = 0, check_count = 0, weCount, eraseCount;
    // Frames: write, write-all, enable, short write, boundary write, disable
    row_t rows [9] = '{
        '{{12'h0, 1'b1, nv_write_pkg::OP_WRITE, 9'h155, 8'ha5}, 20, 1'b0, 1'b0},
        '{{12'h0, 1'b1, nv_write_pkg::OP_EXT, nv_write_pkg::EXT_WRITE_ENTIRE_ARRAY, 7'h00, 8'h3c}, 20, 1'b0, 1'b0},
        '{{20'h0, 1'b1, nv_write_pkg::OP_EXT, nv_write_pkg::EXT_EN, 7'h00}, 12, 1'b0, 1'b0},
        '{{12'h0, 1'b1, nv_write_pkg::OP_WRITE, 9'h155, 8'ha5}, 20, 1'b1, 1'b0},
        '{{13'h0, 1'b1, nv_write_pkg::OP_WRITE, 9'h0aa, 7'h3f}, 19, 1'b0, 1'b0},
        '{{12'h0, 1'b1, nv_write_pkg::OP_WRITE, 9'h1ff, 8'h00}, 20, 1'b1, 1'b0},
        '{{12'h0, 1'b1, nv_write_pkg::OP_EXT, nv_write_pkg::EXT_WRITE_ENTIRE_ARRAY, 7'h00, 8'h3c}, 20, 1'b1, 1'b1},
        '{{20'h0, 1'b1, nv_write_pkg::OP_EXT, nv_write_pkg::EXT_DIS, 7'h00}, 12, 1'b0, 1'b0},
        '{{12'h0, 1'b1, nv_write_pkg::OP_WRITE, 9'h0f0, 8'h11}, 20, 1'b0, 1'b0}};

    // ==========================================================
    // Clock, design and host
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    serial_eeprom_write_cycle #(.PROG_CYC(40))
        serial_eeprom_write_cycle_inst (.core_clk(core_clk), .reset_n(reset_n),
        .chipSel(chipSel), .serialClk(serialClk), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .memWe(memWe), .memAll(memAll),
        .memAddr(memAddr), .memData(memData), .memErase(memErase),
        .progEnabled(progEnabled), .busy(busy));
    three_wire_host three_wire_host_inst (.core_clk(core_clk), .chipSel(chipSel),
        .serialClk(serialClk), .serialIn(serialIn));

    // Count array strobes and keep what the program phase carried
    always @(posedge core_clk) begin
        if (memWe === 1'b1) begin
            weCount++;
            if (memErase === 1'b1) eraseCount++;
            else begin
                allSeen  = memAll;
                addrSeen = memAddr;
                dataSeen = memData;
            end
        end
    end

    // ==========================================================
    // Checking and ending
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 100 && busy === 1'b1; k++) @(posedge core_clk);
        three_wire_host_inst.tick(6);
        #1;
    endtask
    // Poll status in mid-cycle and after it
    task automatic status_case(input logic [31:0] bits);
        @(posedge core_clk);
        three_wire_host_inst.send_frame(bits, 20);
        three_wire_host_inst.raise_for_status();
        #1;
        check("status driven", serialOutEn, 1'b1);
        check("status busy", serialOut, 1'b0);
        wait_idle();
        check("status held", serialOutEn, 1'b1);
        check("status ready", serialOut, 1'b1);
        three_wire_host_inst.drop_select();
        $display("Status case done");
    endtask

    // Watchdog cuts a hang short
    initial begin
        #400000;
        fails++;
        $display("ERROR watchdog expected finish seen hang");
        complete_run();
    end

    // ==========================================================
    // Main sequence
    initial begin
        reset_n = 1'b0;
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        three_wire_host_inst.tick(8);
        foreach (rows[i]) begin
            weCount    = 0;
            eraseCount = 0;
            @(posedge core_clk);
            three_wire_host_inst.send_frame(rows[i].bits, rows[i].n);
            three_wire_host_inst.tick(8);
            #1;
            check("busy", busy, rows[i].expBusy);
            check("no status while low", serialOutEn, 1'b0);
            wait_idle();
            check("writes", weCount, rows[i].expBusy ? 2 : 0);
            check("erases", eraseCount, rows[i].expBusy ? 1 : 0);
            if (rows[i].expBusy) begin
                check("whole", allSeen, rows[i].expAll);
                check("data", dataSeen, rows[i].bits[7:0]);
                if (!rows[i].expAll) check("addr", addrSeen, rows[i].bits[16:8]);
            end
            $display("Row %0d done", i);
        end
        @(posedge core_clk);
        three_wire_host_inst.send_frame(rows[2].bits, 12);
        three_wire_host_inst.tick(8);
        #1;
        check("enabled", progEnabled, 1'b1);
        status_case(rows[3].bits);
        status_case(rows[6].bits);
        reset_n <= 1'b0;
        three_wire_host_inst.tick(3);
        reset_n <= 1'b1;
        three_wire_host_inst.tick(2);
        #1;
        check("enabled after reset", progEnabled, 1'b0);
        check("busy after reset", busy, 1'b0);
        check("status after reset", serialOutEn, 1'b0);
        check("write after reset", memWe, 1'b0);
        $display("Reset case done");
        complete_run();
    end
endmodule
